/* core/fwd_pkg.sv */
// Shared constants of the frequency watchdog and recovery control block.
// Assumes a 50 MHz core clock and byte-wide control bytes from an SMBus
// slave engine outside this block.
package fwd_pkg;
  // Control byte indices
  localparam logic [2:0] IDX_CFG = 3'h0;
  localparam logic [2:0] IDX_COUNT = 3'h1;
  localparam logic [2:0] IDX_SOFT_SEL = 3'h2;
  localparam logic [2:0] IDX_NUM = 3'h3;
  localparam logic [2:0] IDX_DEN = 3'h4;
  localparam logic [2:0] IDX_REC_NUM = 3'h5;
  localparam logic [2:0] IDX_REC_DEN = 3'h6;
  localparam logic [2:0] IDX_STATUS = 3'h7;
  // Configuration byte bit positions
  localparam int B_CUSTOM_EN = 0;
  localparam int B_OVERRIDE = 1;
  localparam int B_DOG_EN = 2;
  localparam int B_SCALE = 3;
  localparam int B_RST_WD = 4;
  localparam int B_RST_FC = 5;
  localparam int B_REC_SRC = 6;
  localparam int B_FLAG = 7;
  // Status byte bit positions
  localparam int B_ST_RECOVERY = 0;
  localparam int B_ST_RUNNING = 1;
  // Field widths
  localparam int SEL_W = 5;
  localparam int CNT_W = 5;
  localparam int NUM_W = 8;
  localparam int DEN_W = 7;
  // Offset added to numerator and denominator in the frequency formula
  localparam logic [NUM_W:0] NUM_OFFSET = 9'h003;
  localparam logic [DEN_W:0] DEN_OFFSET = 8'h03;
  // Reset values
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [CNT_W-1:0] RST_COUNT = 5'h1F;
  localparam logic [SEL_W-1:0] RST_SEL = 5'h00;
  localparam logic [NUM_W-1:0] RST_NUM = 8'h00;
  localparam logic [DEN_W-1:0] RST_DEN = 7'h00;
  // Tick timing
  localparam int unsigned CLK_KHZ = 50000;
  localparam int unsigned TICK_SHORT_MS = 150;
  localparam int unsigned TICK_LONG_MS = 2500;
  localparam int unsigned TICK_SHORT_CYC = TICK_SHORT_MS * CLK_KHZ;
  localparam int unsigned TICK_LONG_CYC = TICK_LONG_MS * CLK_KHZ;
  localparam int TICK_W = 27;
  localparam int unsigned RST_PULSE_CYC = 16;
  // Watchdog states
  typedef enum logic [3:0] {
    DOG_OFF = 4'h1,
    DOG_ARMED = 4'h2,
    DOG_COUNT = 4'h4,
    DOG_EXPIRED = 4'h8
  } dog_state_e;
endpackage : fwd_pkg

/* core/fwd_tick.sv */
// Tick generator of the watchdog: one pulse per selected tick period.
// Assumes restart is a one-cycle pulse that realigns the period.
`timescale 1ns/100ps
module fwd_tick #(
  parameter int unsigned SHORT_CYC = fwd_pkg::TICK_SHORT_CYC,
  parameter int unsigned LONG_CYC = fwd_pkg::TICK_LONG_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic restart,
  input wire logic scale_sel,
  output logic tick
);
  import fwd_pkg::*;
  localparam logic [TICK_W-1:0] SHORT_M1 = TICK_W'(SHORT_CYC - 1);
  localparam logic [TICK_W-1:0] LONG_M1 = TICK_W'(LONG_CYC - 1);
  logic [TICK_W-1:0] cnt_ff;
  logic tick_ff;
  // Period limit from the scale bit
  wire [TICK_W-1:0] limit = scale_sel ? LONG_M1 : SHORT_M1;
  wire at_end = (cnt_ff >= limit);
  wire [TICK_W-1:0] nxt_cnt = (restart || at_end) ? '0 : cnt_ff + 1'b1;
  // Cycle counter and tick pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= at_end && !restart;
    end
  end
  assign tick = tick_ff;
endmodule : fwd_tick

/* core/fwd_pulse.sv */
// Fixed-length pulse stretcher for the system reset output.
// Assumes trig is a one-cycle event; a new event restarts the pulse.
`timescale 1ns/100ps
module fwd_pulse #(
  parameter int unsigned LEN = fwd_pkg::RST_PULSE_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic trig,
  output logic pulse
);
  logic [7:0] left_ff;
  logic pulse_ff;
  wire [7:0] nxt_left = trig ? 8'(LEN) : (left_ff != 8'h00 ?
                        left_ff - 8'h01 : 8'h00);
  // Remaining length and registered output
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      left_ff <= 8'h00;
      pulse_ff <= 1'b0;
    end else begin
      left_ff <= nxt_left;
      pulse_ff <= nxt_left != 8'h00;
    end
  end
  assign pulse = pulse_ff;
endmodule : fwd_pulse

/* core/fwd_watchdog.sv */
// Control logic of the frequency watchdog: control bytes, watchdog,
// recovery switch, frequency selection and reset pulse.
// Assumes an SMBus slave engine delivers control byte writes and reads,
// and the gear constant table lives outside behind GEAR_SEL.
`timescale 1ns/100ps
module fwd_watchdog #(
  parameter int unsigned SHORT_CYC = fwd_pkg::TICK_SHORT_CYC,
  parameter int unsigned LONG_CYC = fwd_pkg::TICK_LONG_CYC,
  parameter int unsigned PULSE_CYC = fwd_pkg::RST_PULSE_CYC
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [fwd_pkg::SEL_W-1:0] STRAP_SELECT_PINS,
  input wire logic CTRL_WE,
  input wire logic [2:0] CTRL_ADDR,
  input wire logic [7:0] CTRL_WDATA,
  output logic [7:0] CTRL_RDATA,
  output logic [fwd_pkg::SEL_W-1:0] GEAR_SEL,
  output logic CUSTOM_ACTIVE,
  output logic [fwd_pkg::NUM_W:0] NUM_TERM,
  output logic [fwd_pkg::DEN_W:0] DEN_TERM,
  output logic FREQ_LOAD,
  output logic TIMEOUT_FLAG,
  output logic SYS_RESET_PULSE
);
  import fwd_pkg::*;

  logic [7:0] cfg_ff;
  logic flag_ff;
  logic [CNT_W-1:0] timeout_count_ff;
  logic [SEL_W-1:0] soft_sel_ff;
  logic [NUM_W-1:0] numerator_ff;
  logic [DEN_W-1:0] denominator_ff;
  logic [NUM_W-1:0] rec_num_ff;
  logic [DEN_W-1:0] rec_den_ff;
  logic [SEL_W-1:0] strap_latched_ff;
  logic strap_taken_ff;
  logic recovery_ff;
  dog_state_e state_ff, nxt_state;
  logic [CNT_W-1:0] count_ff, nxt_count;
  logic [7:0] rdata_ff;
  logic [SEL_W-1:0] gear_ff;
  logic custom_ff;
  logic [NUM_W:0] num_term_ff;
  logic [DEN_W:0] den_term_ff;
  logic load_ff;
  logic tick;

  // Write decode
  wire wr_cfg = CTRL_WE && (CTRL_ADDR == IDX_CFG);
  wire wr_count = CTRL_WE && (CTRL_ADDR == IDX_COUNT);
  wire wr_sel = CTRL_WE && (CTRL_ADDR == IDX_SOFT_SEL);
  wire wr_num = CTRL_WE && (CTRL_ADDR == IDX_NUM);
  wire wr_den = CTRL_WE && (CTRL_ADDR == IDX_DEN);
  wire wr_rnum = CTRL_WE && (CTRL_ADDR == IDX_REC_NUM);
  wire wr_rden = CTRL_WE && (CTRL_ADDR == IDX_REC_DEN);

  // Configuration fields
  wire custom_en = cfg_ff[B_CUSTOM_EN];
  wire strap_override = cfg_ff[B_OVERRIDE];
  wire dog_enable = cfg_ff[B_DOG_EN];
  wire tick_scale_sel = cfg_ff[B_SCALE];
  wire reset_on_timeout_en = cfg_ff[B_RST_WD];
  wire reset_on_freq_change_en = cfg_ff[B_RST_FC];
  wire recovery_source_sel = cfg_ff[B_REC_SRC];

  // Frequency change events raised by software writes
  wire cfg_freq_bits = wr_cfg &&
    ((CTRL_WDATA[B_CUSTOM_EN] != custom_en) ||
     (CTRL_WDATA[B_OVERRIDE] != strap_override));
  wire nm_change = (wr_num || wr_den) && custom_en;
  wire sel_change = wr_sel && strap_override;
  wire freq_change = cfg_freq_bits || nm_change || sel_change;
  wire w1c = wr_cfg && CTRL_WDATA[B_FLAG];
  wire dog_off_wr = wr_cfg && !CTRL_WDATA[B_DOG_EN];

  // Watchdog countdown events
  wire expire = (state_ff == DOG_COUNT) && (count_ff == '0) && !dog_off_wr;
  wire reload = (state_ff == DOG_ARMED || state_ff == DOG_COUNT) &&
                freq_change && !dog_off_wr;
  // Re-entry from the expired state also realigns the tick period
  wire rearm = (state_ff == DOG_EXPIRED) && dog_enable && freq_change &&
               !dog_off_wr;
  wire tick_restart = reload || rearm;
  wire rst_trig = (expire && reset_on_timeout_en) ||
                  (freq_change && reset_on_freq_change_en);

  // Control byte storage
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_ff <= RST_CFG;
      timeout_count_ff <= RST_COUNT;
      soft_sel_ff <= RST_SEL;
      numerator_ff <= RST_NUM;
      denominator_ff <= RST_DEN;
      rec_num_ff <= RST_NUM;
      rec_den_ff <= RST_DEN;
    end else begin
      if (wr_cfg) cfg_ff <= {1'b0, CTRL_WDATA[6:0]};
      if (wr_count) timeout_count_ff <= CTRL_WDATA[CNT_W-1:0];
      if (wr_sel) soft_sel_ff <= CTRL_WDATA[SEL_W-1:0];
      if (wr_num) numerator_ff <= CTRL_WDATA[NUM_W-1:0];
      if (wr_den) denominator_ff <= CTRL_WDATA[DEN_W-1:0];
      if (wr_rnum) rec_num_ff <= CTRL_WDATA[NUM_W-1:0];
      if (wr_rden) rec_den_ff <= CTRL_WDATA[DEN_W-1:0];
    end
  end

  // Sticky flag; expiry wins over a clear in the same cycle
  wire nxt_flag = expire || (flag_ff && !w1c);

  // Strap capture after reset release, recovery latch, flag
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      strap_latched_ff <= RST_SEL;
      strap_taken_ff <= 1'b0;
      recovery_ff <= 1'b0;
      flag_ff <= 1'b0;
    end else begin
      if (!strap_taken_ff) strap_latched_ff <= STRAP_SELECT_PINS;
      strap_taken_ff <= 1'b1;
      recovery_ff <= expire || (recovery_ff && !freq_change);
      flag_ff <= nxt_flag;
    end
  end

  // Watchdog state machine
  always_comb begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    case (state_ff)
      DOG_OFF: begin
        nxt_count = timeout_count_ff;
        if (wr_cfg && CTRL_WDATA[B_DOG_EN]) nxt_state = DOG_ARMED;
      end
      DOG_ARMED: begin
        nxt_count = timeout_count_ff;
        if (reload) nxt_state = DOG_COUNT;
      end
      DOG_COUNT: begin
        if (reload) begin
          nxt_count = timeout_count_ff;
        end else if (expire) begin
          nxt_state = DOG_EXPIRED;
        end else if (tick && count_ff != '0) begin
          nxt_count = count_ff - 1'b1;
        end
      end
      DOG_EXPIRED: begin
        nxt_count = '0;
        if (dog_enable && freq_change) begin
          nxt_state = DOG_COUNT;
          nxt_count = timeout_count_ff;
        end
      end
      default: nxt_state = DOG_OFF;
    endcase
    if (dog_off_wr) begin
      nxt_state = DOG_OFF;
      nxt_count = timeout_count_ff;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff <= DOG_OFF;
      count_ff <= RST_COUNT;
    end else begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
    end
  end

  // Tick timebase, realigned on every reload
  fwd_tick #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_tick (
    .clk(CLK),
    .arst_n(ARST_N),
    .restart(tick_restart),
    .scale_sel(tick_scale_sel),
    .tick(tick)
  );

  // Reset pulse stretcher
  fwd_pulse #(.LEN(PULSE_CYC)) u_pulse (
    .clk(CLK),
    .arst_n(ARST_N),
    .trig(rst_trig),
    .pulse(SYS_RESET_PULSE)
  );

  // Frequency selection; host keeps (N+3)/(M+3) above one
  wire [SEL_W-1:0] sel_src = strap_override ? soft_sel_ff
                                            : strap_latched_ff;
  wire rec_strap = recovery_ff && !recovery_source_sel;
  wire rec_nm = recovery_ff && recovery_source_sel;
  wire [SEL_W-1:0] nxt_gear = rec_strap ? strap_latched_ff : sel_src;
  wire nxt_custom = rec_nm || (custom_en && !rec_strap);
  wire [NUM_W-1:0] n_val = rec_nm ? rec_num_ff : numerator_ff;
  wire [DEN_W-1:0] m_val = rec_nm ? rec_den_ff : denominator_ff;
  wire [NUM_W:0] nxt_num_term = {1'b0, n_val} + NUM_OFFSET;
  wire [DEN_W:0] nxt_den_term = {1'b0, m_val} + DEN_OFFSET;

  // Read mux
  wire [7:0] status_byte = {6'h00, state_ff == DOG_COUNT, recovery_ff};
  wire [7:0] nxt_rdata =
    (CTRL_ADDR == IDX_CFG) ? {flag_ff, cfg_ff[6:0]} :
    (CTRL_ADDR == IDX_COUNT) ? {3'h0, timeout_count_ff} :
    (CTRL_ADDR == IDX_SOFT_SEL) ? {3'h0, soft_sel_ff} :
    (CTRL_ADDR == IDX_NUM) ? numerator_ff :
    (CTRL_ADDR == IDX_DEN) ? {1'b0, denominator_ff} :
    (CTRL_ADDR == IDX_REC_NUM) ? rec_num_ff :
    (CTRL_ADDR == IDX_REC_DEN) ? {1'b0, rec_den_ff} : status_byte;

  // Registered outputs
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_ff <= 8'h00;
      gear_ff <= RST_SEL;
      custom_ff <= 1'b0;
      num_term_ff <= NUM_OFFSET;
      den_term_ff <= DEN_OFFSET;
      load_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      gear_ff <= nxt_gear;
      custom_ff <= nxt_custom;
      num_term_ff <= nxt_num_term;
      den_term_ff <= nxt_den_term;
      load_ff <= freq_change || expire;
    end
  end

  assign CTRL_RDATA = rdata_ff;
  assign GEAR_SEL = gear_ff;
  assign CUSTOM_ACTIVE = custom_ff;
  assign NUM_TERM = num_term_ff;
  assign DEN_TERM = den_term_ff;
  assign FREQ_LOAD = load_ff;
  assign TIMEOUT_FLAG = flag_ff;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_flag_on_expiry: assert property (expire |=> TIMEOUT_FLAG)
    else $error("flag not set on expiry");
  a_flag_w1c_clear: assert property (w1c && !expire |=> !TIMEOUT_FLAG)
    else $error("flag not cleared by write of one");
  a_flag_sticky: assert property (TIMEOUT_FLAG && !w1c |=> TIMEOUT_FLAG)
    else $error("flag dropped without clear");
  a_count_reload: assert property (reload |=>
    count_ff == $past(timeout_count_ff))
    else $error("count not reloaded");
  a_count_per_tick: assert property (state_ff == DOG_COUNT && tick &&
    count_ff != '0 && !reload && !dog_off_wr |=>
    count_ff == $past(count_ff) - 1'b1)
    else $error("count not decremented on tick");
  a_count_steady: assert property (state_ff == DOG_COUNT && !tick &&
    !reload |=> $stable(count_ff) || state_ff != DOG_COUNT)
    else $error("count moved without tick");
  a_dog_stop: assert property (dog_off_wr |=> state_ff == DOG_OFF &&
    count_ff == $past(timeout_count_ff))
    else $error("watchdog not stopped");
  a_rst_on_expiry: assert property (expire && reset_on_timeout_en |=>
    SYS_RESET_PULSE [*2])
    else $error("no reset pulse after expiry");
  a_rst_cause: assert property (!SYS_RESET_PULSE ##1 SYS_RESET_PULSE |->
    $past(rst_trig))
    else $error("reset pulse without cause");
  a_recovery_strap: assert property (expire && !recovery_source_sel &&
    !wr_cfg |=> ##1 !CUSTOM_ACTIVE && GEAR_SEL == strap_latched_ff)
    else $error("recovery to straps missing");
  a_custom_terms: assert property (custom_en && !recovery_ff |=>
    NUM_TERM == {1'b0, $past(numerator_ff)} + NUM_OFFSET)
    else $error("numerator term wrong");
  a_gear_source: assert property (!recovery_ff |=> GEAR_SEL ==
    ($past(strap_override) ? $past(soft_sel_ff) : $past(strap_latched_ff)))
    else $error("gear source wrong");
  a_load_on_nm: assert property (nm_change |=> FREQ_LOAD)
    else $error("no load after N or M write");

  c_expiry: cover property (expire);
  c_reset_wd: cover property (expire && reset_on_timeout_en);
  c_recovery_nm: cover property (recovery_ff && recovery_source_sel);
  c_reset_fc: cover property (freq_change && reset_on_freq_change_en);
endmodule : fwd_watchdog

/* dv/fwd_sys_model.sv */
// System side of the block: strap resistors and the reset receiver.
// Assumes the reset pulse is active high and synchronous to clk.
`timescale 1ns/100ps
module fwd_sys_model #(
  parameter logic [4:0] STRAPS = 5'h15
) (
  input wire logic clk,
  input wire logic rst_pulse,
  output logic [4:0] straps,
  output int pulses,
  output int last_len
);
  int run = 0;
  int n = 0;
  int len = 0;
  // Straps are fixed resistors, stable from time zero
  assign straps = STRAPS;
  assign pulses = n;
  assign last_len = len;
  // Count each reset pulse and measure its length in cycles
  always @(posedge clk) begin
    if (rst_pulse === 1'b1) begin
      run++;
    end else if (run != 0) begin
      n++;
      len = run;
      run = 0;
    end
  end
endmodule : fwd_sys_model

/* dv/fwd_watchdog_test.sv */
// Self-checking bench of the frequency watchdog control block.
// Assumes shortened tick and pulse lengths; system side is modelled.
`timescale 1ns/100ps
module fwd_watchdog_test;
  import fwd_pkg::*;
  localparam int SHORT = 20;
  localparam int LONG = 50;
  localparam int PLEN = 4;
  localparam logic [4:0] STRAPS = 5'h15;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic we = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [4:0] straps;
  logic [7:0] rdata;
  logic [4:0] gear;
  logic custom;
  logic [8:0] num;
  logic [7:0] den;
  logic load;
  logic flag;
  logic rst_pulse;
  int pulses;
  int last_len;
  int loads;
  int n_errors = 0;
  int samples_checked = 0;
  logic [7:0] rst_tab [8] = '{8'h00, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h00,
                              8'h00, 8'h00};

  fwd_watchdog #(.SHORT_CYC(SHORT), .LONG_CYC(LONG), .PULSE_CYC(PLEN)) i_dut (
    .CLK(clk), .ARST_N(arst_n), .STRAP_SELECT_PINS(straps), .CTRL_WE(we),
    .CTRL_ADDR(addr), .CTRL_WDATA(wdata), .CTRL_RDATA(rdata),
    .GEAR_SEL(gear), .CUSTOM_ACTIVE(custom), .NUM_TERM(num),
    .DEN_TERM(den), .FREQ_LOAD(load), .TIMEOUT_FLAG(flag),
    .SYS_RESET_PULSE(rst_pulse)
  );

  fwd_sys_model #(.STRAPS(STRAPS)) i_sys (
    .clk(clk), .rst_pulse(rst_pulse), .straps(straps), .pulses(pulses),
    .last_len(last_len)
  );

  // Clock of 20 ns period
  initial begin
    forever #10 clk = ~clk;
  end

  // Compare and count; four-state so unknowns never match
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One control byte write, then count load pulses over four cycles
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    we = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    we = 1'b0;
    loads = 0;
    // Load pulse stands in the cycle right after the write edge
    repeat (4) begin
      if (load === 1'b1) loads++;
      @(negedge clk);
    end
  endtask : wr

  // Read a control byte: registered data one cycle after the address
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    check({1'b0, rdata}, {1'b0, exp});
  endtask : rd

  // Expiry must land within a few cycles of count times tick
  task automatic wait_flag(input int exp);
    int n;
    n = 4;
    while (flag !== 1'b1 && n < exp + 10) begin
      @(negedge clk);
      n++;
    end
    check({8'h00, n >= exp && n <= exp + 4}, 9'h001);
  endtask : wait_flag

  // Counts, verdict and end of run
  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // Hang guard, well beyond the expected few thousand cycles
  initial begin
    #(20 * 20000);
    n_errors++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 8; i++) rd(3'(i), rst_tab[i]);
    check(num, 9'h003);
    check({1'b0, den}, 9'h003);
    check({4'h0, gear}, {4'h0, STRAPS});
    check({8'h00, custom}, 9'h000);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    // Custom rate: 100/96 keeps the ratio above one
    wr(3'h0, 8'h01);
    wr(3'h3, 8'h61);
    check(9'(loads), 9'h001);
    wr(3'h4, 8'hDD);
    check(9'(loads), 9'h001);
    check(num, 9'h064);
    check({1'b0, den}, 9'h060);
    check({8'h00, custom}, 9'h001);
    rd(3'h4, 8'h5D);
    check(9'(pulses), 9'h000);
    // Reset pulse after a frequency change
    wr(3'h0, 8'h21);
    wr(3'h3, 8'hFF);
    repeat (8) @(negedge clk);
    check(9'(pulses), 9'h001);
    check(9'(last_len), 9'(PLEN));
    check(num, 9'h102);
    // Drop the change reset first; the enable in force decides
    wr(3'h0, 8'h01);
    // Software select with strap override
    wr(3'h0, 8'h02);
    wr(3'h2, 8'h0A);
    check({4'h0, gear}, 9'h00A);
    check({8'h00, custom}, 9'h000);
    wr(3'h0, 8'h00);
    check({4'h0, gear}, {4'h0, STRAPS});
    check(9'(pulses), 9'h001);
    // Longest short-scale interval, reset on expiry, strap recovery
    wr(3'h1, 8'h1F);
    wr(3'h0, 8'h14);
    wr(3'h0, 8'h15);
    wait_flag(31 * SHORT);
    repeat (8) @(negedge clk);
    check(9'(pulses), 9'h002);
    check(9'(last_len), 9'(PLEN));
    rd(3'h0, 8'h95);
    rd(3'h7, 8'h01);
    check({8'h00, custom}, 9'h000);
    check({4'h0, gear}, {4'h0, STRAPS});
    wr(3'h0, 8'h15);
    check({8'h00, flag}, 9'h001);
    wr(3'h0, 8'h95);
    check({8'h00, flag}, 9'h000);
    // Stop mid-count, then arm without a frequency change
    wr(3'h0, 8'h14);
    repeat (100) @(negedge clk);
    wr(3'h0, 8'h10);
    repeat (700) @(negedge clk);
    check({8'h00, flag}, 9'h000);
    rd(3'h7, 8'h00);
    wr(3'h0, 8'h14);
    repeat (700) @(negedge clk);
    check({8'h00, flag}, 9'h000);
    // Shortest long-scale interval, no reset, recovery from N and M
    wr(3'h5, 8'h20);
    wr(3'h6, 8'h10);
    wr(3'h1, 8'h01);
    wr(3'h0, 8'h4C);
    wr(3'h0, 8'h4D);
    wait_flag(LONG);
    repeat (8) @(negedge clk);
    check(9'(pulses), 9'h002);
    check({8'h00, custom}, 9'h001);
    check(num, 9'h023);
    check({1'b0, den}, 9'h013);
    rd(3'h0, 8'hCD);
    // Reset in mid-run clears flag, recovery and watchdog state
    arst_n = 1'b0;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    check({8'h00, flag}, 9'h000);
    check({8'h00, custom}, 9'h000);
    check({4'h0, gear}, {4'h0, STRAPS});
    rd(3'h7, 8'h00);
    rd(3'h1, 8'h1F);
    stop_test();
  end
endmodule : fwd_watchdog_test
